// File: common/hsc_params.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a 10 MHz module clock; included by bare name.
//
// Behaviour
// - Run mode shows health steadily on and fault off.
// - Fault states: both on, health off with fault blink, fault on only.
// - Boot mode blinks both health and fault indicators.
// - Channel one activity indicator blinks while its function counts or times.
// - Channel two activity indicator blinks while its function counts or times.
// - Each output indicator is lit exactly while its output conducts.
// - One indicator per input point shows its live state.
// - Two independent input channels of four points each.
// - Four individually switched output points.
// - Stored configuration selects the role of every input and output.
// - Program and run modes; the host commands switching.
// - Runtime output parameter writes report success or failure.
// - Host can read and write the internal registers.
// - Position and rate scaling for counters, interval scaling for timers.
// - Timing mode derives a velocity from count arrival rate, scalable.
// - Up to two quadrature encoders, one per channel.
// - Each encoder counter has external reset and inhibit inputs.
// - Count equal to setpoint fires assigned outputs without the host.
// - While inhibited the counter holds and ignores pulses.
// - Counts are signed, 31-bit magnitude plus sign.
// - Timers are 32-bit unsigned with one microsecond resolution.
// - Quadrature 1X, 2X, 4X plus simple up and down counting.
// - Outputs set, reset, pulse on, pulse off, toggle or reset count.
`ifndef HSC_PARAMS_SVH
`define HSC_PARAMS_SVH

`define RA_CTRL   4'h0
`define RA_CFG1   4'h1
`define RA_CFG2   4'h2
`define RA_SP1    4'h3
`define RA_SP2    4'h4
`define RA_OCFG   4'h5
`define RA_POS1   4'h6
`define RA_POS2   4'h7
`define RA_VAL1   4'h8
`define RA_VAL2   4'h9
`define RA_STAT   4'ha
`define RA_PW     4'hb
`define RA_SCL1   4'hc
`define RA_SCL2   4'hd
`define RA_VEL1   4'he
`define RA_VEL2   4'hf

`define F_RUN     0
`define F_EN      3
`define F_OSRC    3
`define SCL_SHIFT 8

`define RST_CFG   4'h0
`define RST_OCFG  16'h0000
`define RST_PW    32'h0000_03e8
`define RST_SCL   16'h0100

`define CLK_NS    100
`define US_NS     1000
`define BLINK_MS  250
`define GATE_MS   100
`define US_CYC    ((`US_NS + `CLK_NS - 1) / `CLK_NS)
`define BLINK_CYC (`BLINK_MS * 1000000 / `CLK_NS)
`define GATE_CYC  (`GATE_MS * 1000000 / `CLK_NS)

`endif

// File: common/hsc_pkg.sv
// Types shared by the counter and status logic.
// Assumes nothing of its surroundings.
`default_nettype none
package hsc_pkg;

    typedef enum logic [1:0] {
        MODE_PROG = 2'b01,
        MODE_RUN  = 2'b10
    } mode_t;

    typedef enum logic [2:0] {
        CM_QUAD1 = 3'h0,
        CM_QUAD2 = 3'h1,
        CM_QUAD4 = 3'h2,
        CM_UP    = 3'h3,
        CM_DOWN  = 3'h4,
        CM_TIMER = 3'h5
    } cnt_mode_t;

    typedef enum logic [2:0] {
        OA_SET    = 3'h0,
        OA_RST    = 3'h1,
        OA_PON    = 3'h2,
        OA_POFF   = 3'h3,
        OA_TOG    = 3'h4,
        OA_RSTCNT = 3'h5
    } out_act_t;

endpackage
`default_nettype wire

// File: hdl/hsc_reg_mem.sv
// Sixteen-word store for host-written registers.
// Assumes one write and one read port on the module clock.
`timescale 1ns/1ps
`default_nettype none
module hsc_reg_mem (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        we_in,
    input  wire logic [3:0]  waddr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  raddr_in,
    output logic      [31:0] rdata_out
);
    logic [31:0] mem_r [16];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_r[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= mem_r[raddr_in];
        end
    end
endmodule // hsc_reg_mem
`default_nettype wire

// File: hdl/hs_counter_status_logic.sv
// Two-channel counter/timer with setpoint outputs and status indicators.
// Assumes field inputs already synchronous-capable and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_params.svh"
module hs_counter_status_logic #(
    parameter int unsigned BLINK_CYC = `BLINK_CYC,
    parameter int unsigned GATE_CYC  = `GATE_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [3:0]  chan_one_in_points_in,
    input  wire logic [3:0]  chan_two_in_points_in,
    input  wire logic        boot_mode_in,
    input  wire logic        hw_fail_in,
    input  wire logic        diag_fail_in,
    input  wire logic        wdog_timeout_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    output logic             reg_rvalid_out,
    output logic             xfer_ok_out,
    output logic             xfer_err_out,
    output logic             run_mode_out,
    output logic [3:0]       discrete_out_points_out,
    output logic             health_led_out,
    output logic             fault_led_out,
    output logic             chan_one_activity_led_out,
    output logic             chan_two_activity_led_out,
    output logic [3:0]       chan_one_in_leds_out,
    output logic [3:0]       chan_two_in_leds_out,
    output logic [3:0]       out_leds_out
);
    // Quadrature step: {valid, up}. Up when the previous A equals the new B.
    function automatic logic [1:0] qstep(input hsc_pkg::cnt_mode_t m,
                                         input logic ap, input logic bp,
                                         input logic a, input logic b);
        logic ae;
        logic be;
        logic dir;
        ae  = a ^ ap;
        be  = b ^ bp;
        dir = ~(ap ^ b);
        unique case (m)
            hsc_pkg::CM_QUAD1: qstep = {ae & a, dir};
            hsc_pkg::CM_QUAD2: qstep = {ae, dir};
            hsc_pkg::CM_QUAD4: qstep = {ae | be, ae ? dir : (a ^ bp)};
            hsc_pkg::CM_UP:    qstep = {ae & a, 1'b1};
            hsc_pkg::CM_DOWN:  qstep = {ae & a, 1'b0};
            default:           qstep = 2'b00;
        endcase
    endfunction

    // Signed value times an 8.8 fixed-point scale factor.
    function automatic logic [31:0] scl(input logic signed [31:0] v,
                                        input logic [15:0] f);
        logic signed [48:0] p;
        p   = v * $signed({1'b0, f});
        scl = p[31+`SCL_SHIFT:`SCL_SHIFT];
    endfunction

    logic [7:0]  s1_r;
    logic [7:0]  s2_r;
    logic [7:0]  s3_r;
    logic [3:0]  us_cnt_r;
    logic [31:0] bl_cnt_r;
    logic        blink_r;
    logic [31:0] gt_cnt_r;
    hsc_pkg::mode_t mode_r;
    logic [3:0]  cfg_r [2];
    logic [31:0] sp_r [2];
    logic [15:0] scl_r [2];
    logic [15:0] ocfg_r;
    logic [31:0] pw_r;
    logic        rd_p1_r;
    logic        ro_p1_r;
    logic [31:0] live_r;
    logic [31:0] mem_rdata;
    logic [1:0]  hit_v;
    logic [1:0]  act_v;
    logic [1:0]  rc_req;
    logic [7:0]  rc_o;
    logic [63:0] pos_v;
    logic [63:0] val_v;
    logic [63:0] vel_v;
    logic [3:0]  out_nxt;

    // Two-stage input synchronisers; the third stage is the edge reference.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s1_r <= 8'h00;
            s2_r <= 8'h00;
            s3_r <= 8'h00;
        end else begin
            s1_r <= {chan_two_in_points_in, chan_one_in_points_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    wire us_tick = (us_cnt_r == 4'(`US_CYC - 1));
    wire bl_tick = (bl_cnt_r == BLINK_CYC - 1);
    wire gt_tick = (gt_cnt_r == GATE_CYC - 1);
    wire run     = (mode_r == hsc_pkg::MODE_RUN);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            us_cnt_r <= 4'h0;
            bl_cnt_r <= 32'h0000_0000;
            gt_cnt_r <= 32'h0000_0000;
            blink_r  <= 1'b0;
        end else begin
            us_cnt_r <= us_tick ? 4'h0 : us_cnt_r + 4'h1;
            bl_cnt_r <= bl_tick ? 32'h0000_0000 : bl_cnt_r + 32'h0000_0001;
            gt_cnt_r <= gt_tick ? 32'h0000_0000 : gt_cnt_r + 32'h0000_0001;
            blink_r  <= bl_tick ? ~blink_r : blink_r;
        end
    end

    // Host write checks: read-only words, channel roles outside program
    // mode and undefined output actions are refused.
    wire a_ro = (reg_addr_in == `RA_POS1) || (reg_addr_in == `RA_POS2) ||
                (reg_addr_in == `RA_VAL1) || (reg_addr_in == `RA_VAL2) ||
                (reg_addr_in == `RA_STAT) || (reg_addr_in == `RA_VEL1) ||
                (reg_addr_in == `RA_VEL2);
    wire a_cfg = (reg_addr_in == `RA_CFG1) || (reg_addr_in == `RA_CFG2);
    wire bad_oact = (reg_addr_in == `RA_OCFG) &&
                    ((reg_wdata_in[2:0] > 3'h5) || (reg_wdata_in[6:4] > 3'h5) ||
                     (reg_wdata_in[10:8] > 3'h5) || (reg_wdata_in[14:12] > 3'h5));
    wire wr_ok  = reg_wr_in && !a_ro && !(a_cfg && run) && !bad_oact;
    wire wr_err = reg_wr_in && !wr_ok;
    wire ok_at  = wr_ok && (reg_addr_in == `RA_CTRL);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_r       <= hsc_pkg::MODE_PROG;
            xfer_ok_out  <= 1'b0;
            xfer_err_out <= 1'b0;
            run_mode_out <= 1'b0;
        end else begin
            unique case (mode_r)
                hsc_pkg::MODE_PROG: if (ok_at && reg_wdata_in[`F_RUN]) begin
                    mode_r <= hsc_pkg::MODE_RUN;
                end
                hsc_pkg::MODE_RUN: if (ok_at && !reg_wdata_in[`F_RUN]) begin
                    mode_r <= hsc_pkg::MODE_PROG;
                end
            endcase
            if (reg_wr_in) begin
                xfer_ok_out  <= wr_ok;
                xfer_err_out <= wr_err;
            end
            run_mode_out <= (ok_at) ? reg_wdata_in[`F_RUN] : run;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cfg_r[0] <= `RST_CFG;
            cfg_r[1] <= `RST_CFG;
            sp_r[0]  <= 32'h0000_0000;
            sp_r[1]  <= 32'h0000_0000;
            scl_r[0] <= `RST_SCL;
            scl_r[1] <= `RST_SCL;
            ocfg_r   <= `RST_OCFG;
            pw_r     <= `RST_PW;
        end else if (wr_ok) begin
            unique case (reg_addr_in)
                `RA_CFG1: cfg_r[0] <= reg_wdata_in[3:0];
                `RA_CFG2: cfg_r[1] <= reg_wdata_in[3:0];
                `RA_SP1:  sp_r[0]  <= reg_wdata_in;
                `RA_SP2:  sp_r[1]  <= reg_wdata_in;
                `RA_SCL1: scl_r[0] <= reg_wdata_in[15:0];
                `RA_SCL2: scl_r[1] <= reg_wdata_in[15:0];
                `RA_OCFG: ocfg_r   <= reg_wdata_in[15:0];
                `RA_PW:   pw_r     <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Per-channel counting, timing and rate measurement.
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic signed [31:0] cnt_r;
        logic [31:0] tmr_r;
        logic [31:0] ivl_r;
        logic [31:0] edg_r;
        logic [31:0] rate_r;
        logic        hit_r;
        wire a   = s2_r[4*c];
        wire b   = s2_r[4*c+1];
        wire rst = s2_r[4*c+2];
        wire inh = s2_r[4*c+3];
        wire ap  = s3_r[4*c];
        wire bp  = s3_r[4*c+1];
        wire hsc_pkg::cnt_mode_t m = hsc_pkg::cnt_mode_t'(cfg_r[c][2:0]);
        wire active = run && cfg_r[c][`F_EN] && !inh;
        wire [1:0] st = qstep(m, ap, bp, a, b);
        wire stp_v = active && st[1];
        wire a_rise = a && !ap;
        wire tmode = (m == hsc_pkg::CM_TIMER);
        wire signed [31:0] cnt_st = st[0] ? cnt_r + 32'sd1 : cnt_r - 32'sd1;
        wire clr = rst || rc_req[c];
        wire t_ev = active && tmode && a_rise;

        always_ff @(posedge clk_in) begin
            if (sys_rst_in) begin
                cnt_r  <= 32'sd0;
                tmr_r  <= 32'h0000_0000;
                ivl_r  <= 32'h0000_0000;
                edg_r  <= 32'h0000_0000;
                rate_r <= 32'h0000_0000;
                hit_r  <= 1'b0;
            end else begin
                cnt_r <= clr ? 32'sd0 : (stp_v ? cnt_st : cnt_r);
                hit_r <= !clr && stp_v && (cnt_st == sp_r[c]);
                if (clr || t_ev) begin
                    tmr_r <= 32'h0000_0000;
                end else if (active && tmode && us_tick && tmr_r != 32'hffff_ffff) begin
                    tmr_r <= tmr_r + 32'h0000_0001;
                end
                if (clr) begin
                    ivl_r <= 32'h0000_0000;
                end else if (t_ev) begin
                    ivl_r <= tmr_r;
                end
                if (gt_tick) begin
                    rate_r <= edg_r;
                    edg_r  <= 32'h0000_0000;
                end else if (stp_v || t_ev) begin
                    edg_r <= edg_r + 32'h0000_0001;
                end
            end
        end

        assign hit_v[c] = hit_r;
        assign act_v[c] = active && (tmode || cfg_r[c][2:0] <= 3'h4);
        assign pos_v[32*c +: 32] = scl(cnt_r, scl_r[c]);
        assign val_v[32*c +: 32] = tmode ? scl(ivl_r, scl_r[c]) : scl(rate_r, scl_r[c]);
        assign vel_v[32*c +: 32] = scl(rate_r, scl_r[c]);
    end

    // Per-output setpoint actions, run without host involvement.
    for (genvar o = 0; o < 4; o++) begin : g_out
        logic [31:0] pc_r;
        wire hsc_pkg::out_act_t act = hsc_pkg::out_act_t'(ocfg_r[4*o +: 3]);
        wire src = ocfg_r[4*o + `F_OSRC];
        wire ev  = run && hit_v[src];
        wire cur = discrete_out_points_out[o];
        wire p_end = (pc_r == 32'h0000_0001) && us_tick;
        wire ev_val = (act == hsc_pkg::OA_SET || act == hsc_pkg::OA_PON) ? 1'b1 :
                      (act == hsc_pkg::OA_RST || act == hsc_pkg::OA_POFF) ? 1'b0 :
                      (act == hsc_pkg::OA_TOG) ? ~cur : cur;
        wire pulse = (act == hsc_pkg::OA_PON) || (act == hsc_pkg::OA_POFF);

        assign out_nxt[o] = !run ? 1'b0 : ev ? ev_val :
                            p_end ? (act == hsc_pkg::OA_POFF) : cur;
        assign rc_o[2*o]   = ev && (act == hsc_pkg::OA_RSTCNT) && !src;
        assign rc_o[2*o+1] = ev && (act == hsc_pkg::OA_RSTCNT) && src;

        always_ff @(posedge clk_in) begin
            if (sys_rst_in || !run) begin
                pc_r <= 32'h0000_0000;
            end else if (ev) begin
                pc_r <= pulse ? pw_r : 32'h0000_0000;
            end else if (pc_r != 32'h0000_0000 && us_tick) begin
                pc_r <= pc_r - 32'h0000_0001;
            end
        end
    end

    assign rc_req[0] = rc_o[0] | rc_o[2] | rc_o[4] | rc_o[6];
    assign rc_req[1] = rc_o[1] | rc_o[3] | rc_o[5] | rc_o[7];

    // Health and fault indicator encoding, highest priority first.
    wire h_nxt = boot_mode_in ? blink_r :
                 hw_fail_in ? 1'b1 :
                 (wdog_timeout_in || diag_fail_in) ? 1'b0 :
                 run ? 1'b1 : blink_r;
    wire f_nxt = boot_mode_in ? blink_r :
                 hw_fail_in ? 1'b1 :
                 wdog_timeout_in ? 1'b1 :
                 diag_fail_in ? blink_r : 1'b0;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            discrete_out_points_out   <= 4'h0;
            out_leds_out              <= 4'h0;
            health_led_out            <= 1'b0;
            fault_led_out             <= 1'b0;
            chan_one_activity_led_out <= 1'b0;
            chan_two_activity_led_out <= 1'b0;
            chan_one_in_leds_out      <= 4'h0;
            chan_two_in_leds_out      <= 4'h0;
        end else begin
            discrete_out_points_out   <= out_nxt;
            out_leds_out              <= out_nxt;
            health_led_out            <= h_nxt;
            fault_led_out             <= f_nxt;
            chan_one_activity_led_out <= act_v[0] && blink_r;
            chan_two_activity_led_out <= act_v[1] && blink_r;
            chan_one_in_leds_out      <= s2_r[3:0];
            chan_two_in_leds_out      <= s2_r[7:4];
        end
    end

    // Register read: live values snapshot in the request cycle, stored
    // words come out of the memory one cycle later.
    wire [31:0] stat_w = {26'h0, xfer_err_out, xfer_ok_out, act_v, 1'b0, run};
    wire [31:0] live_w = (reg_addr_in == `RA_POS1) ? pos_v[31:0] :
                         (reg_addr_in == `RA_POS2) ? pos_v[63:32] :
                         (reg_addr_in == `RA_VAL1) ? val_v[31:0] :
                         (reg_addr_in == `RA_VAL2) ? val_v[63:32] :
                         (reg_addr_in == `RA_VEL1) ? vel_v[31:0] :
                         (reg_addr_in == `RA_VEL2) ? vel_v[63:32] : stat_w;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_p1_r        <= 1'b0;
            ro_p1_r        <= 1'b0;
            live_r         <= 32'h0000_0000;
            reg_rdata_out  <= 32'h0000_0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            rd_p1_r        <= reg_rd_in;
            ro_p1_r        <= a_ro;
            live_r         <= live_w;
            reg_rvalid_out <= rd_p1_r;
            if (rd_p1_r) begin
                reg_rdata_out <= ro_p1_r ? live_r : mem_rdata;
            end
        end
    end

    hsc_reg_mem u_mem (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .we_in      (wr_ok),
        .waddr_in   (reg_addr_in),
        .wdata_in   (reg_wdata_in),
        .raddr_in   (reg_addr_in),
        .rdata_out  (mem_rdata)
    );
endmodule // hs_counter_status_logic
`default_nettype wire

// File: dv/hsc_assertions.sv
// Port-level assertions for the counter and status logic.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module hsc_assertions (
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic [3:0] chan_one_in_points_in,
    input wire logic       boot_mode_in,
    input wire logic       hw_fail_in,
    input wire logic       diag_fail_in,
    input wire logic       wdog_timeout_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic       reg_rvalid_out,
    input wire logic       xfer_ok_out,
    input wire logic       xfer_err_out,
    input wire logic       run_mode_out,
    input wire logic [3:0] discrete_out_points_out,
    input wire logic       health_led_out,
    input wire logic       fault_led_out,
    input wire logic       chan_one_activity_led_out,
    input wire logic [3:0] chan_one_in_leds_out,
    input wire logic [3:0] out_leds_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic quiet = !boot_mode_in && !hw_fail_in && !diag_fail_in && !wdog_timeout_in;

    led_mirror_a: assert property (out_leds_out == discrete_out_points_out)
        else $error("output indicators differ from outputs");
    run_leds_a: assert property ((run_mode_out && quiet) [*3] |-> health_led_out && !fault_led_out)
        else $error("run mode indicators wrong");
    hw_fail_a: assert property ((hw_fail_in && !boot_mode_in) [*3] |-> health_led_out && fault_led_out)
        else $error("hardware failure indicators wrong");
    wdog_leds_a: assert property ((wdog_timeout_in && !boot_mode_in && !hw_fail_in) [*3]
        |-> !health_led_out && fault_led_out)
        else $error("watchdog indicators wrong");
    boot_unison_a: assert property (boot_mode_in [*3] |-> health_led_out == fault_led_out)
        else $error("boot indicators not in unison");
    in_leds_a: assert property (chan_one_in_leds_out == $past(chan_one_in_points_in, 3))
        else $error("input indicators do not follow points");
    read_answer_a: assert property (reg_rd_in |-> ##2 reg_rvalid_out)
        else $error("read not answered");
    rvalid_cause_a: assert property (reg_rvalid_out |-> $past(reg_rd_in, 2))
        else $error("read valid without request");
    ro_refuse_a: assert property (reg_wr_in && reg_addr_in == 4'h6
        |-> ##[1:2] (xfer_err_out && !xfer_ok_out))
        else $error("read-only write not refused");
    prog_quiet_a: assert property (!run_mode_out [*2]
        |-> discrete_out_points_out == 4'h0 && !chan_one_activity_led_out)
        else $error("outputs active in program mode");
endmodule // hsc_assertions

bind hs_counter_status_logic hsc_assertions chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .chan_one_in_points_in(chan_one_in_points_in),
    .boot_mode_in(boot_mode_in), .hw_fail_in(hw_fail_in), .diag_fail_in(diag_fail_in),
    .wdog_timeout_in(wdog_timeout_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_rvalid_out(reg_rvalid_out), .xfer_ok_out(xfer_ok_out),
    .xfer_err_out(xfer_err_out), .run_mode_out(run_mode_out),
    .discrete_out_points_out(discrete_out_points_out), .health_led_out(health_led_out),
    .fault_led_out(fault_led_out), .chan_one_activity_led_out(chan_one_activity_led_out),
    .chan_one_in_leds_out(chan_one_in_leds_out), .out_leds_out(out_leds_out));
`default_nettype wire

// File: dv/field_points.sv
// Field device model: encoder phases, reset and inhibit points of one channel.
// Assumes its tasks are called from the bench on the module clock.
`timescale 1ns/1ps
`default_nettype none
module field_points (
    input  wire logic       clk_in,
    output var  logic [3:0] pts_out
);
    initial pts_out = 4'h0;

    // Each level is held three cycles so the two-flop sync catches it.
    task automatic hold(input logic [3:0] v);
        @(posedge clk_in);
        pts_out <= v;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic set(input int idx, input logic v);
        logic [3:0] n;
        n = pts_out;
        n[idx] = v;
        hold(n);
    endtask

    task automatic pulse(input int idx);
        set(idx, 1'b1);
        set(idx, 1'b0);
    endtask

    // One full encoder cycle with phase A leading phase B.
    task automatic quad;
        hold({pts_out[3:2], 2'b01});
        hold({pts_out[3:2], 2'b11});
        hold({pts_out[3:2], 2'b10});
        hold({pts_out[3:2], 2'b00});
    endtask
endmodule // field_points
`default_nettype wire

// File: dv/hs_counter_status_logic_tb.sv
// Self-checking bench for the counter and status logic.
// Assumes the checker is bound to the design and field models drive both channels.
`timescale 1ns/1ps
`default_nettype none
module hs_counter_status_logic_tb;
    localparam int BLINK = 8;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        boot, hw, diag, wdog;
    logic        wr, rd;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    wire logic [3:0]  p1, p2, dout, l1, l2, ol;
    wire logic [31:0] rdata;
    wire logic        rvalid, ok, err, run, hl, fl, a1, a2;
    int num_errors = 0;
    int total_checks = 0;
    int tg[4];

    always #50 clk_in = ~clk_in;

    field_points fp1 (.clk_in(clk_in), .pts_out(p1));
    field_points fp2 (.clk_in(clk_in), .pts_out(p2));

    hs_counter_status_logic #(.BLINK_CYC(BLINK), .GATE_CYC(16)) dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .chan_one_in_points_in(p1),
        .chan_two_in_points_in(p2), .boot_mode_in(boot), .hw_fail_in(hw),
        .diag_fail_in(diag), .wdog_timeout_in(wdog), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .xfer_ok_out(ok), .xfer_err_out(err), .run_mode_out(run),
        .discrete_out_points_out(dout), .health_led_out(hl), .fault_led_out(fl),
        .chan_one_activity_led_out(a1), .chan_two_activity_led_out(a2),
        .chan_one_in_leds_out(l1), .chan_two_in_leds_out(l2), .out_leds_out(ol));

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wrw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic rdw(input logic [3:0] a, input logic [31:0] exp, input string what);
        bit got;
        got = 1'b0;
        @(posedge clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        for (int i = 0; i < 4 && !got; i++) begin
            @(posedge clk_in);
            #1;
            if (rvalid === 1'b1) begin
                got = 1'b1;
                chk(rdata, exp, what);
            end
        end
        if (!got) begin
            num_errors++;
            $display("CHECK FAILED at %0t: read timed out", $time);
            report_and_stop();
        end
    endtask

    // Off, on, blinking, or a single stray change, from a toggle count and final level.
    function automatic logic [1:0] code(input int t, input logic v);
        return t > 1 ? 2'h2 : (t > 0 ? 2'h3 : {1'b0, v});
    endfunction

    task automatic watch;
        logic [3:0] prev, cur;
        repeat (4) @(posedge clk_in);
        #1;
        prev = {hl, fl, a1, a2};
        foreach (tg[i]) tg[i] = 0;
        repeat (3 * BLINK) begin
            @(posedge clk_in);
            #1;
            cur = {hl, fl, a1, a2};
            for (int i = 0; i < 4; i++) if (cur[i] !== prev[i]) tg[i]++;
            prev = cur;
        end
    endtask

    task automatic leds(input logic [1:0] h, input logic [1:0] f);
        watch();
        chk(code(tg[3], hl), h, "health indicator");
        chk(code(tg[2], fl), f, "fault indicator");
    endtask

    task automatic sts(input logic [3:0] v, input logic [1:0] h, f);
        @(posedge clk_in);
        {boot, hw, diag, wdog} <= v;
        leds(h, f);
    endtask

    initial begin
        {wr, rd, boot, hw, diag, wdog} <= 6'h00;
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        chk(run, 1'b0, "mode after reset");
        leds(2'h2, 2'h0);
        $display("test reset done");
        wrw(4'hb, 32'h2);
        rdw(4'hb, 32'h2, "pulse width");
        wrw(4'h6, 32'h5);
        chk({err, ok}, 2'b10, "read-only write");
        wrw(4'h5, 32'h7);
        chk({err, ok}, 2'b10, "bad action");
        wrw(4'h1, 32'hb);
        chk({err, ok}, 2'b01, "channel config");
        wrw(4'h3, 32'h3);
        wrw(4'h4, 32'h100);
        wrw(4'h5, 32'h10);
        wrw(4'h0, 32'h1);
        chk(run, 1'b1, "run mode");
        wrw(4'h1, 32'h9);
        chk({err, ok}, 2'b10, "config in run");
        $display("test registers done");
        leds(2'h1, 2'h0);
        chk(code(tg[1], a1), 2'h2, "channel one activity");
        repeat (3) fp1.pulse(0);
        rdw(4'h6, 32'h3, "up count");
        chk(dout, 4'hd, "setpoint outputs");
        fp1.set(3, 1'b1);
        fp1.pulse(0);
        rdw(4'h6, 32'h3, "inhibited count");
        watch();
        chk(code(tg[1], a1), 2'h0, "activity while inhibited");
        fp1.set(3, 1'b0);
        fp1.pulse(2);
        rdw(4'h6, 32'h0, "reset point");
        wrw(4'h0, 32'h0);
        chk(dout, 4'h0, "outputs in program");
        wrw(4'h1, 32'hc);
        wrw(4'h0, 32'h1);
        fp1.pulse(0);
        fp1.pulse(0);
        rdw(4'h6, 32'hffff_fffe, "down count");
        $display("test channel one done");
        for (int m = 0; m < 3; m++) begin
            wrw(4'h0, 32'h0);
            wrw(4'h2, 32'(8 + m));
            wrw(4'h0, 32'h1);
            fp2.pulse(2);
            fp2.quad();
            rdw(4'h7, 32'h1 << m, "quadrature count");
        end
        watch();
        chk(code(tg[0], a2), 2'h2, "channel two activity");
        fp2.set(3, 1'b1);
        watch();
        chk({l2, a2}, 5'h10, "ch two inhibit");
        $display("test channel two done");
        sts(4'h4, 2'h1, 2'h1);
        sts(4'h1, 2'h0, 2'h1);
        sts(4'h2, 2'h0, 2'h2);
        sts(4'h8, 2'h2, 2'h2);
        sts(4'h0, 2'h1, 2'h0);
        $display("test indicators done");
        report_and_stop();
    end
endmodule // hs_counter_status_logic_tb
`default_nettype wire
